// ==== hdl/aio_defines.vh ====
/*
 * Shared constants for the analog I/O register window: holding-register
 * addresses (decimal values written in hex), group geometry and sizes.
 * Assumes it is included by bare name from each design file that needs it.
 */
`ifndef AIO_DEFINES_VH
`define AIO_DEFINES_VH

// window limits, decimal 6801 and 9098
`define AIO_WIN_FIRST                     16'h1A91
`define AIO_WIN_LAST                      16'h238A

// first gateway slot of each range, decimal 6801 and 8001
`define AIO_IN_BASE                       16'h1A91
`define AIO_OUT_BASE                      16'h1F41

// spacing between I/O-point groups, decimal 150
`define AIO_POINT_STRIDE                  16'h0096

// devices per group (gateway plus nodes 1..47) and points per device
`define AIO_DEVICES                       7'h30
`define AIO_POINTS                        4'h8

// gateway holding registers with printed addresses
`define AIO_ANALOG_INPUT_POINT1_GATEWAY   16'h1A91
`define AIO_ANALOG_INPUT_POINT2_GATEWAY   16'h1B27
`define AIO_ANALOG_INPUT_POINT3_GATEWAY   16'h1BBD
`define AIO_DEVICE_STATUS_GATEWAY         16'h1EAB
`define AIO_ANALOG_OUTPUT_POINT1_GATEWAY  16'h1F41
`define AIO_ANALOG_OUTPUT_POINT2_GATEWAY  16'h1FD7
`define AIO_ANALOG_OUTPUT_POINT3_GATEWAY  16'h206D
`define AIO_ANALOG_OUTPUT_POINT8_GATEWAY  16'h235B

// reset value of the registered answer words
`define AIO_DATA_RESET                    16'h0000

`endif

// ==== hdl/aio_word_ram.v ====
/*
 * Word store: one synchronous write port and two asynchronous read ports.
 * Assumes a single clock; contents are not reset and read as whatever was
 * last written.
 */
`default_nettype none

module aio_word_ram #(
    parameter DW    = 16,
    parameter AW    = 9,
    parameter DEPTH = 384
) (
    input  wire          sys_clk,
    input  wire          ce,
    input  wire          we,
    input  wire [AW-1:0] waddr,
    input  wire [DW-1:0] wdata,
    input  wire [AW-1:0] raddr_a,
    output wire [DW-1:0] rdata_a,
    input  wire [AW-1:0] raddr_b,
    output wire [DW-1:0] rdata_b
);

    reg [DW-1:0] mem [0:DEPTH-1];

    // write only while enabled; the caller keeps addresses in range
    always @(posedge sys_clk)
    begin
        if (ce && we)
        begin
            mem[waddr] <= wdata;
        end
    end

    // combinational reads, the callers register the result
    assign rdata_a = mem[raddr_a];
    assign rdata_b = mem[raddr_b];

endmodule // aio_word_ram

`default_nettype wire

// ==== hdl/aio_addr_decode.v ====
/*
 * Address decoder for the analog window: splits a decimal holding-register
 * address into range, I/O point and device slot.
 * Assumes a 16-bit address; purely combinational.
 */
`default_nettype none
`include "aio_defines.vh"

module aio_addr_decode (
    input  wire [15:0] addr,
    output reg         hit,
    output reg         is_out,
    output reg  [2:0]  point,
    output reg  [5:0]  dev
);

    wire [7:0]  in_hit;
    wire [7:0]  out_hit;
    wire [47:0] in_slot;
    wire [47:0] out_slot;

    // one comparator pair per point group, 150 apart in both ranges
    genvar p;
    generate
        for (p = 0; p < 8; p = p + 1)
        begin : g_point
            localparam [31:0] IB = `AIO_IN_BASE + p * `AIO_POINT_STRIDE;
            localparam [31:0] OB = `AIO_OUT_BASE + p * `AIO_POINT_STRIDE;
            wire [31:0] in_off  = {16'h0000, addr} - IB;
            wire [31:0] out_off = {16'h0000, addr} - OB;
            assign in_hit[p]  = ({16'h0000, addr} >= IB) && (in_off < 32'h0000_0030);
            assign out_hit[p] = ({16'h0000, addr} >= OB) && (out_off < 32'h0000_0030);
            assign in_slot[p*6 +: 6]  = in_off[5:0];
            assign out_slot[p*6 +: 6] = out_off[5:0];
        end
    endgenerate

    // groups never overlap, so at most one bit is set
    integer i;
    always @*
    begin
        hit    = 1'b0;
        is_out = 1'b0;
        point  = 3'h0;
        dev    = 6'h00;
        for (i = 0; i < 8; i = i + 1)
        begin
            if (in_hit[i])
            begin
                hit   = 1'b1;
                point = i[2:0];
                dev   = in_slot[i*6 +: 6];
            end
            if (out_hit[i])
            begin
                hit    = 1'b1;
                is_out = 1'b1;
                point  = i[2:0];
                dev    = out_slot[i*6 +: 6];
            end
        end
    end

endmodule // aio_addr_decode

`default_nettype wire

// ==== hdl/aio_register_map.v ====
/*
 * Analog I/O register window: stores one 16-bit value per I/O point for
 * the gateway and 47 nodes, inputs and outputs, and serves multi-register
 * holding-register reads and writes from the protocol side while the
 * radio side fills inputs and collects outputs.
 * Assumes a protocol engine that frames requests, and a radio engine that
 * writes input values and reads output values; both synchronous to sys_clk.
 */
// Summary of operation
// - decode window 6801..9098, grouped by point
// - input point 1: 48 words from 6801
// - gateway lowest, then nodes by address
// - 16-bit words, one burst covers a point
// - output point 1 at 8001, nodes follow
// - point 2 at 6951 and 8151
// - point 3 at 7101 and 8301
// - input 8 is status, output 8 9051
// - node 47 is 48th slot, 6848
`default_nettype none
`include "aio_defines.vh"

module aio_register_map #(
    parameter DW      = 16,
    parameter MAX_CNT = 48
) (
    input  wire          sys_clk,
    input  wire          rst_n,
    input  wire          ce,
    // protocol side
    input  wire          mb_req,
    input  wire          mb_write,
    input  wire [15:0]   mb_addr,
    input  wire [6:0]    mb_count,
    input  wire          mb_wvalid,
    input  wire [DW-1:0] mb_wdata,
    output reg           mb_busy,
    output reg           mb_rvalid,
    output reg  [DW-1:0] mb_rdata,
    output reg           mb_wack,
    output reg           mb_done,
    output reg           mb_err,
    // radio side, input values
    input  wire          fld_in_we,
    input  wire [2:0]    fld_in_point,
    input  wire [5:0]    fld_in_dev,
    input  wire [DW-1:0] fld_in_data,
    // radio side, output values
    input  wire [2:0]    fld_out_point,
    input  wire [5:0]    fld_out_dev,
    output reg  [DW-1:0] fld_out_data,
    output reg           fld_out_upd,
    output reg  [2:0]    fld_upd_point,
    output reg  [5:0]    fld_upd_dev
);

    localparam DEPTH = 384;
    localparam AW    = 9;

    // one-hot states
    localparam [1:0] ST_IDLE = 2'b01;
    localparam [1:0] ST_RUN  = 2'b10;

    // flat index: point groups of 48, gateway first then node order
    // same index for either range:
    //   index = 48 * point + slot, point counted from 0
    //   slot 0 is the gateway, slots 1..47 the nodes
    // the product is built as 64p - 16p to keep it to adders
    function [AW-1:0] slot_index;
        input [2:0] pt;
        input [5:0] dv;
        begin
            slot_index = {pt, 6'h00} - {2'b00, pt, 4'h0} + {3'b000, dv};
        end
    endfunction

    reg  [1:0]    state;
    reg  [2:0]    cur_point;
    reg  [5:0]    cur_dev;
    reg  [6:0]    remain;
    reg           cur_out;
    reg           cur_write;

    wire          dec_hit;
    wire          dec_out;
    wire [2:0]    dec_point;
    wire [5:0]    dec_dev;
    wire [DW-1:0] in_rd;
    wire [DW-1:0] out_rd_mb;
    wire [DW-1:0] out_rd_fld;
    wire [AW-1:0] cur_idx;
    wire [AW-1:0] fld_in_idx;
    wire [AW-1:0] fld_out_idx;
    wire [7:0]    span_end;
    wire          req_ok;
    wire          take_word;
    wire          fld_in_ok;
    wire          fld_out_ok;
    wire          cnt_ok;
    wire          span_ok;
    wire          dir_ok;
    wire          rd_word;
    wire          wr_word;

    // address split into range, point, slot
    aio_addr_decode u_dec (
        .addr   (mb_addr),
        .hit    (dec_hit),
        .is_out (dec_out),
        .point  (dec_point),
        .dev    (dec_dev)
    );

    assign cur_idx     = slot_index(cur_point, cur_dev);
    assign fld_in_idx  = slot_index(fld_in_point, fld_in_dev);
    assign fld_out_idx = slot_index(fld_out_point, fld_out_dev);

    // count of 1..MAX_CNT words per request
    assign cnt_ok   = (mb_count != 7'h00) && (mb_count <= MAX_CNT[6:0]);

    // a burst must stay inside one point group
    assign span_end = {2'b00, dec_dev} + {1'b0, mb_count};
    assign span_ok  = (span_end <= {1'b0, `AIO_DEVICES});

    // inputs belong to the radio side, so protocol writes there are refused
    assign dir_ok   = !mb_write || dec_out;

    // refusal is all or nothing, no partial burst is ever started
    assign req_ok   = dec_hit && cnt_ok && span_ok && dir_ok;

    // one word moves per cycle on reads, per strobe on writes
    assign take_word = (state == ST_RUN) && (!cur_write || mb_wvalid);

    // the same move split by direction
    assign rd_word   = take_word && !cur_write;
    assign wr_word   = take_word && cur_write;

    // slots 48..63 do not exist, drop such radio writes
    assign fld_in_ok = fld_in_we && (fld_in_dev < 6'h30);

    // same limit on readback, a bad slot reads as zero instead of past the store
    assign fld_out_ok = (fld_out_dev < 6'h30);

    // input values: written by radio, read by protocol side
    // input store of 384 words, 8 point groups of 48
    aio_word_ram #(
        .DW    (DW),
        .AW    (AW),
        .DEPTH (DEPTH)
    ) u_in_ram (
        .sys_clk (sys_clk),
        .ce      (ce),
        .we      (fld_in_ok),
        .waddr   (fld_in_idx),
        .wdata   (fld_in_data),
        .raddr_a (cur_idx),
        .rdata_a (in_rd),
        .raddr_b (fld_in_idx),
        .rdata_b ()
    );

    // output values: written by protocol side, read by radio
    // output group mirrors inputs
    aio_word_ram #(
        .DW    (DW),
        .AW    (AW),
        .DEPTH (DEPTH)
    ) u_out_ram (
        .sys_clk (sys_clk),
        .ce      (ce),
        .we      (take_word && cur_write),
        .waddr   (cur_idx),
        .wdata   (mb_wdata),
        .raddr_a (cur_idx),
        .rdata_a (out_rd_mb),
        .raddr_b (fld_out_idx),
        .rdata_b (out_rd_fld)
    );

    // request sequencer; requests while busy are ignored
    always @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state     <= ST_IDLE;
            cur_point <= 3'h0;
            cur_dev   <= 6'h00;
            remain    <= 7'h00;
            cur_out   <= 1'b0;
            cur_write <= 1'b0;
            mb_busy   <= 1'b0;
            mb_done   <= 1'b0;
            mb_err    <= 1'b0;
        end
        else if (ce)
        begin
            mb_done <= 1'b0;
            mb_err  <= 1'b0;
            case (state)
                ST_IDLE:
                begin
                    if (mb_req)
                    begin
                        if (req_ok)
                        begin
                            state     <= ST_RUN;
                            cur_point <= dec_point;
                            cur_dev   <= dec_dev;
                            remain    <= mb_count;
                            cur_out   <= dec_out;
                            cur_write <= mb_write;
                            mb_busy   <= 1'b1;
                        end
                        else
                        begin
                            // whole request refused, nothing transferred
                            mb_done <= 1'b1;
                            mb_err  <= 1'b1;
                        end
                    end
                end
                ST_RUN:
                begin
                    if (take_word)
                    begin
                        cur_dev <= cur_dev + 6'h01;
                        remain  <= remain - 7'h01;
                        if (remain == 7'h01)
                        begin
                            state   <= ST_IDLE;
                            mb_busy <= 1'b0;
                            mb_done <= 1'b1;
                        end
                    end
                end
                default:
                begin
                    state   <= ST_IDLE;
                    mb_busy <= 1'b0;
                end
            endcase
        end
    end

    // read answer: data held until the next read word
    always @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            mb_rvalid <= 1'b0;
            mb_rdata  <= `AIO_DATA_RESET;
        end
        else if (ce)
        begin
            mb_rvalid <= rd_word;
            if (rd_word)
            begin
                mb_rdata <= cur_out ? out_rd_mb : in_rd;
            end
        end
    end

    // write acknowledge, one pulse per stored word
    always @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            mb_wack <= 1'b0;
        end
        else if (ce)
        begin
            mb_wack <= wr_word;
        end
    end

    // radio side: output readback and change notice
    always @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            fld_out_data  <= `AIO_DATA_RESET;
            fld_out_upd   <= 1'b0;
            fld_upd_point <= 3'h0;
            fld_upd_dev   <= 6'h00;
        end
        else if (ce)
        begin
            // one cycle late; a same-cycle write shows next cycle
            fld_out_data <= fld_out_ok ? out_rd_fld : `AIO_DATA_RESET;
            fld_out_upd  <= take_word && cur_write;
            if (take_word && cur_write)
            begin
                fld_upd_point <= cur_point;
                fld_upd_dev   <= cur_dev;
            end
        end
    end

endmodule // aio_register_map

`default_nettype wire

// ==== tb/aio_register_map_chk.sv ====
/*
 * Port checker for the analog register window, bound to its top module.
 * Assumes ce held high and requests spaced as the protocol side allows.
 */
`default_nettype none
module aio_chk (
    input wire logic        sys_clk,
    input wire logic        rst_n,
    input wire logic        ce,
    input wire logic        mb_req,
    input wire logic        mb_write,
    input wire logic [15:0] mb_addr,
    input wire logic [6:0]  mb_count,
    input wire logic        mb_wvalid,
    input wire logic        mb_busy,
    input wire logic        mb_rvalid,
    input wire logic        mb_wack,
    input wire logic        mb_done,
    input wire logic        mb_err,
    input wire logic        fld_out_upd,
    input wire logic [5:0]  fld_upd_dev
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    // request taken only when idle
    wire take = ce && mb_req && !mb_busy;
    sequence s_refuse;
        mb_done && mb_err;
    endsequence
    sequence s_one_word;
        mb_busy ##1 (mb_rvalid && mb_done && !mb_err);
    endsequence
    a_err_has_done: assert property (mb_err |-> mb_done) else $error("err without done");
    a_done_idle: assert property (mb_done |-> !mb_busy) else $error("busy with done");
    a_take_answer: assert property (take |=> (mb_busy or s_refuse)) else $error("no answer");
    a_input_ro: assert property (take && mb_write && mb_addr < 16'h1F41 |=> s_refuse)
        else $error("input write taken");
    a_count_bad: assert property (take && (mb_count == 7'h00 || mb_count > 7'h30) |=> s_refuse)
        else $error("bad count taken");
    // last word past the 48th slot of the first group
    a_group_end: assert property (take && mb_addr >= 16'h1A91 && mb_addr < 16'h1AC1 &&
        (mb_addr + mb_count) > 16'h1AC1 |=> s_refuse) else $error("overrun taken");
    a_edge_read: assert property (take && !mb_write && mb_count == 7'h01 &&
        (mb_addr == 16'h1A91 || mb_addr == 16'h238A) |=> s_one_word) else $error("edge read");
    a_wack_cause: assert property (mb_wack |-> $past(mb_wvalid)) else $error("stray wack");
    a_upd_wack: assert property (mb_wack |-> fld_out_upd && $past(mb_busy)) else $error("no update");
    a_upd_dev: assert property (fld_out_upd |-> fld_upd_dev < 6'h30) else $error("bad dev");
endmodule // aio_chk
bind aio_register_map aio_chk chk_u (.sys_clk, .rst_n, .ce, .mb_req, .mb_write, .mb_addr,
    .mb_count, .mb_wvalid, .mb_busy, .mb_rvalid, .mb_wack, .mb_done, .mb_err, .fld_out_upd,
    .fld_upd_dev);
`default_nettype wire

// ==== tb/aio_client.sv ====
/*
 * Protocol client model: frames read and write bursts of holding registers.
 * Assumes the window is idle when a burst starts; one word in flight.
 */
`default_nettype none
module aio_client (
    input  wire logic        sys_clk,
    output var  logic        mb_req,
    output var  logic        mb_write,
    output var  logic [15:0] mb_addr,
    output var  logic [6:0]  mb_count,
    output var  logic        mb_wvalid,
    output var  logic [15:0] mb_wdata,
    input  wire logic        mb_busy,
    input  wire logic        mb_rvalid,
    input  wire logic [15:0] mb_rdata,
    input  wire logic        mb_wack,
    input  wire logic        mb_done,
    input  wire logic        mb_err
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] wbuf [0:47];
    logic [15:0] rbuf [0:47];
    logic        err;
    initial
    begin
        mb_req = 1'b0;
        mb_write = 1'b0;
        mb_addr = 16'h0000;
        mb_count = 7'h00;
        mb_wvalid = 1'b0;
        mb_wdata = 16'h0000;
        err = 1'b0;
    end
    // one request covers n consecutive words from address a
    task automatic xfer(input logic w, input logic [15:0] a, input logic [6:0] n);
        int s;
        int r;
        bit fin;
        s = 0;
        r = 0;
        fin = 0;
        @(posedge sys_clk);
        mb_req <= 1'b1;
        mb_write <= w;
        mb_addr <= a;
        mb_count <= n;
        @(posedge sys_clk);
        // taken here; released address shows its inverse
        mb_req <= 1'b0;
        mb_addr <= ~a;
        if (w)
        begin
            mb_wvalid <= 1'b1;
            mb_wdata <= wbuf[0];
            s = 1;
        end
        // no cycle limit here: a hang is caught by the bench watchdog
        while (!fin)
        begin
            @(posedge sys_clk);
            if (mb_rvalid && r < 48)
            begin
                rbuf[r] = mb_rdata;
                r++;
            end
            fin = mb_done;
            err = mb_err;
            // next word only once the last was acknowledged
            if (mb_wvalid)
            begin
                mb_wvalid <= 1'b0;
                mb_wdata <= ~mb_wdata;
            end
            else if (mb_wack && s < n)
            begin
                mb_wvalid <= 1'b1;
                mb_wdata <= wbuf[s];
                s++;
            end
        end
    endtask
endmodule // aio_client
`default_nettype wire

// ==== tb/aio_register_map_tb.sv ====
/*
 * Bench for the analog register window: radio side driven here, protocol
 * side through the client model. Assumes ce high except in the enable scenario.
 */
`default_nettype none
module aio_register_map_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        sys_clk, rst_n, ce, mb_req, mb_write, mb_wvalid, mb_busy, mb_rvalid, mb_wack;
    logic [8:0]  upd_seen = 9'h1FF;
    logic        mb_done, mb_err, fld_in_we, fld_out_upd;
    logic [15:0] mb_addr, mb_wdata, mb_rdata, fld_in_data, fld_out_data;
    logic [6:0]  mb_count;
    logic [2:0]  fld_in_point, fld_out_point, fld_upd_point;
    logic [5:0]  fld_in_dev, fld_out_dev, fld_upd_dev;
    int          n_mismatch = 0;
    int          tests_run = 0;
    aio_register_map dut_u (.*);
    // last radio-side change notice, kept for the output scenarios
    always @(posedge sys_clk)
        if (fld_out_upd)
            upd_seen <= {fld_upd_point, fld_upd_dev};
    aio_client cli_u (.*);
    initial
    begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic fput(input logic [2:0] p, input logic [5:0] d, input logic [15:0] v);
        @(posedge sys_clk);
        fld_in_we <= 1'b1;
        fld_in_point <= p;
        fld_in_dev <= d;
        fld_in_data <= v;
        @(posedge sys_clk);
        fld_in_we <= 1'b0;
        fld_in_data <= ~v;
    endtask
    task automatic t_in_points;
        for (int p = 0; p < 8; p++)
        begin
            fput(p[2:0], 6'h00, 16'hA000 + p[15:0]);
            cli_u.xfer(1'b0, 16'h1A91 + 16'h0096 * p[15:0], 7'h01);
            chk(cli_u.rbuf[0], 16'hA000 + p[15:0]);
        end
    endtask
    task automatic t_in_group;
        fput(3'h0, 6'h01, 16'h1111);
        fput(3'h0, 6'h2E, 16'h4646);
        fput(3'h0, 6'h2F, 16'h4747);
        cli_u.xfer(1'b0, 16'h1A91, 7'h30);
        chk(cli_u.rbuf[0], 16'hA000);
        chk(cli_u.rbuf[1], 16'h1111);
        chk(cli_u.rbuf[46], 16'h4646);
        chk(cli_u.rbuf[47], 16'h4747);
    endtask
    task automatic t_out_points;
        for (int p = 0; p < 8; p++)
        begin
            cli_u.wbuf[0] = 16'hB000 + p[15:0];
            cli_u.xfer(1'b1, 16'h1F41 + 16'h0096 * p[15:0], 7'h01);
            fld_out_point <= p[2:0];
            fld_out_dev <= 6'h00;
            repeat (2) @(posedge sys_clk);
            chk(fld_out_data, 16'hB000 + p[15:0]);
            chk({7'h00, upd_seen}, {7'h00, p[2:0], 6'h00});
        end
    endtask
    task automatic t_out_burst;
        for (int i = 0; i < 3; i++)
            cli_u.wbuf[i] = 16'hC000 + i[15:0];
        cli_u.xfer(1'b1, 16'h1F41, 7'h03);
        cli_u.xfer(1'b0, 16'h1F41, 7'h03);
        for (int i = 0; i < 3; i++)
            chk(cli_u.rbuf[i], 16'hC000 + i[15:0]);
        cli_u.wbuf[0] = 16'h5A5A;
        cli_u.xfer(1'b1, 16'h238A, 7'h01);
        cli_u.xfer(1'b0, 16'h238A, 7'h01);
        chk(cli_u.rbuf[0], 16'h5A5A);
    endtask
    task automatic t_refuse;
        logic [15:0] ra [6] = '{16'h1A91, 16'h1A91, 16'h1A91, 16'h1AC0, 16'h238B, 16'h1AC1};
        logic [6:0]  rn [6] = '{7'h01, 7'h00, 7'h31, 7'h02, 7'h01, 7'h01};
        cli_u.wbuf[0] = 16'hDEAD;
        for (int i = 0; i < 6; i++)
        begin
            cli_u.xfer(i == 0, ra[i], rn[i]);
            chk(cli_u.err, 1'b1);
        end
        cli_u.xfer(1'b0, 16'h1A91, 7'h01);
        chk(cli_u.rbuf[0], 16'hA000);
    endtask
    // radio write while ce is low must not land
    task automatic t_ce;
        fput(3'h0, 6'h05, 16'h1234);
        ce <= 1'b0;
        fput(3'h0, 6'h05, 16'h7777);
        ce <= 1'b1;
        cli_u.xfer(1'b0, 16'h1A96, 7'h01);
        chk(cli_u.rbuf[0], 16'h1234);
        chk(cli_u.err, 1'b0);
    endtask
    task automatic end_sim;
        $display("mismatches %0d of %0d checks", n_mismatch, tests_run);
        if (n_mismatch == 0 && tests_run > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // watchdog well past the few hundred cycles the tests need
    initial
    begin
        repeat (20000) @(posedge sys_clk);
        n_mismatch++;
        end_sim;
    end
    initial
    begin
        rst_n = 1'b0;
        ce = 1'b1;
        fld_in_we = 1'b0;
        fld_in_point = 3'h0;
        fld_in_dev = 6'h00;
        fld_in_data = 16'h0000;
        fld_out_point = 3'h0;
        fld_out_dev = 6'h00;
        repeat (4) @(posedge sys_clk);
        rst_n <= 1'b1;
        t_in_points;
        t_in_group;
        t_out_points;
        t_out_burst;
        t_refuse;
        t_ce;
        end_sim;
    end
endmodule // aio_register_map_tb
`default_nettype wire
